// file: design/rivm_prio_enc.sv
// Lowest-index priority encoder over the pending requests
`timescale 1ns/1ps
`default_nettype none
module rivm_prio_enc #(
    parameter int N = 25
) (
    input wire logic [N-1:0] i_req,
    output logic o_any,
    output logic [4:0] o_idx
);
    always_comb begin
        o_any = 1'b0;
        o_idx = 5'h00;
        for (int k = N - 1; k >= 0; k--) begin
            if (i_req[k]) begin
                o_any = 1'b1;
                o_idx = 5'(k);
            end
        end
    end
endmodule
`default_nettype wire

// file: design/rivm_vector_map.sv
// Reset and interrupt vector address generator
`timescale 1ns/1ps
`default_nettype none
`include "rivm_map.svh"
module rivm_vector_map (
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire logic I_BOOT_RESET_FUSE,
    input wire logic I_VECTOR_TABLE_SELECT,
    input wire logic [24:0] I_IRQ,
    input wire logic I_ACK,
    output logic O_VEC_VALID,
    output logic [13:0] O_VEC_ADDR,
    output logic O_IS_RESET,
    output logic [4:0] O_IRQ_IDX
);
    logic rst_a_ff;
    logic rst_b_ff;
    logic fuse_a_ff;
    logic fuse_b_ff;
    logic sel_a_ff;
    logic sel_b_ff;
    logic [24:0] irq_a_ff;
    logic [24:0] irq_b_ff;
    logic [1:0] settle_ff;
    logic settled;
    logic boot_pend_ff;
    logic any;
    logic [4:0] idx;
    logic take_reset;
    logic take_irq;
    logic taken;
    rivm_pkg::rivm_kind_t kind_ff;
    rivm_pkg::rivm_addr_t boot_base;
    rivm_pkg::rivm_addr_t vec_ofs;
    rivm_pkg::rivm_addr_t nxt_addr;

    // Release on the clock so no flop sees a ragged reset edge
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end

    // Fuse level comes from outside; two stages
    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            fuse_a_ff <= 1'b1;
            fuse_b_ff <= 1'b1;
        end else begin
            fuse_a_ff <= I_BOOT_RESET_FUSE;
            fuse_b_ff <= fuse_a_ff;
        end
    end

    // Table select comes from outside; two stages
    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            sel_a_ff <= 1'b0;
            sel_b_ff <= 1'b0;
        end else begin
            sel_a_ff <= I_VECTOR_TABLE_SELECT;
            sel_b_ff <= sel_a_ff;
        end
    end

    // Peripheral request levels; two stages each
    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            irq_a_ff <= 25'h0;
            irq_b_ff <= 25'h0;
        end else begin
            irq_a_ff <= I_IRQ;
            irq_b_ff <= irq_a_ff;
        end
    end

    // Stage two holds the real fuse only after two edges; wait them out
    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            settle_ff <= 2'h0;
        end else if (settle_ff != `RIVM_SETTLE_CYCLES) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    assign settled = (settle_ff == `RIVM_SETTLE_CYCLES);

    rivm_prio_enc #(.N(`RIVM_NUM_IRQ)) u_prio (
        .i_req(irq_b_ff),
        .o_any(any),
        .o_idx(idx)
    );

    // One offset per source; codes past the last source never occur
    always_comb begin
        vec_ofs = `RIVM_OFS_EXT_REQ_0;
        case (idx)
            5'h00: vec_ofs = `RIVM_OFS_EXT_REQ_0;
            5'h01: vec_ofs = `RIVM_OFS_EXT_REQ_1;
            5'h02: vec_ofs = `RIVM_OFS_PIN_CHG_0;
            5'h03: vec_ofs = `RIVM_OFS_PIN_CHG_1;
            5'h04: vec_ofs = `RIVM_OFS_PIN_CHG_2;
            5'h05: vec_ofs = `RIVM_OFS_WDOG_TIMEOUT;
            5'h06: vec_ofs = `RIVM_OFS_T2_CMP_A;
            5'h07: vec_ofs = `RIVM_OFS_T2_CMP_B;
            5'h08: vec_ofs = `RIVM_OFS_T2_OVF;
            5'h09: vec_ofs = `RIVM_OFS_T1_CAPT;
            5'h0a: vec_ofs = `RIVM_OFS_T1_CMP_A;
            5'h0b: vec_ofs = `RIVM_OFS_T1_CMP_B;
            5'h0c: vec_ofs = `RIVM_OFS_T1_OVF;
            5'h0d: vec_ofs = `RIVM_OFS_T0_CMP_A;
            5'h0e: vec_ofs = `RIVM_OFS_T0_CMP_B;
            5'h0f: vec_ofs = `RIVM_OFS_T0_OVF;
            5'h10: vec_ofs = `RIVM_OFS_SER_XFER_DONE;
            5'h11: vec_ofs = `RIVM_OFS_RX_DONE;
            5'h12: vec_ofs = `RIVM_OFS_TX_DATA_EMPTY;
            5'h13: vec_ofs = `RIVM_OFS_TX_DONE;
            5'h14: vec_ofs = `RIVM_OFS_CONV_DONE;
            5'h15: vec_ofs = `RIVM_OFS_DATA_NVM_READY;
            5'h16: vec_ofs = `RIVM_OFS_CMP_EVENT;
            5'h17: vec_ofs = `RIVM_OFS_TWO_WIRE;
            5'h18: vec_ofs = `RIVM_OFS_PROG_STORE_READY;
            default: vec_ofs = `RIVM_OFS_EXT_REQ_0;
        endcase
    end

    // Table base is picked apart from the reset target
    always_comb begin
        if (sel_b_ff) begin
            boot_base = `RIVM_BOOT_RESET_ADDR;
        end else begin
            boot_base = `RIVM_NO_BOOT_BASE;
        end
        nxt_addr = boot_base + vec_ofs;
    end

    // Reset vector always goes first, once per reset
    assign take_reset = (kind_ff == rivm_pkg::RIVM_IDLE) && boot_pend_ff
                        && settled;
    assign take_irq = (kind_ff == rivm_pkg::RIVM_IDLE) && !boot_pend_ff
                      && any;
    assign taken = (kind_ff != rivm_pkg::RIVM_IDLE) && I_ACK;

    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            kind_ff <= rivm_pkg::RIVM_IDLE;
        end else begin
            case (kind_ff)
                rivm_pkg::RIVM_IDLE: begin
                    if (take_reset) begin
                        kind_ff <= rivm_pkg::RIVM_RESET;
                    end else if (take_irq) begin
                        kind_ff <= rivm_pkg::RIVM_IRQ;
                    end
                end
                rivm_pkg::RIVM_RESET: begin
                    if (I_ACK) begin
                        kind_ff <= rivm_pkg::RIVM_IDLE;
                    end
                end
                rivm_pkg::RIVM_IRQ: begin
                    // Ack returns straight to idle; no free cycle before the next request can be taken
                    if (I_ACK) begin
                        kind_ff <= rivm_pkg::RIVM_IDLE;
                    end
                end
                default: begin
                    kind_ff <= rivm_pkg::RIVM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            boot_pend_ff <= 1'b1;
        end else if (take_reset) begin
            boot_pend_ff <= 1'b0;
        end
    end

    // Held until the core takes it
    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            O_VEC_VALID <= 1'b0;
        end else if (take_reset || take_irq) begin
            O_VEC_VALID <= 1'b1;
        end else if (taken) begin
            O_VEC_VALID <= 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            O_IS_RESET <= 1'b0;
        end else if (take_reset) begin
            O_IS_RESET <= 1'b1;
        end else if (take_irq || taken) begin
            O_IS_RESET <= 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            O_VEC_ADDR <= `RIVM_RESET_ADDR;
        end else if (take_reset) begin
            if (fuse_b_ff == `RIVM_FUSE_PROGRAMMED) begin
                O_VEC_ADDR <= `RIVM_BOOT_RESET_ADDR;
            end else begin
                O_VEC_ADDR <= `RIVM_RESET_ADDR;
            end
        end else if (take_irq) begin
            O_VEC_ADDR <= nxt_addr;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            O_IRQ_IDX <= 5'h00;
        end else if (take_irq) begin
            O_IRQ_IDX <= idx;
        end
    end
endmodule
`default_nettype wire

// file: include/rivm_map.svh
// Vector offsets, fuse encoding and widths of the reset and vector map
// Functional notes
// - Any reset starts execution at word address 0x0000 unless fuse relocates.
// - External request 0 vectors to 0x0002, request 1 to 0x0004.
// - Pin-change groups 0..2 at 0x0006/0x0008/0x000A; watchdog at 0x000C.
// - Timer 2 compare A, compare B, overflow at 0x000E/0x0010/0x0012.
// - Timer 1 capture, compare A, B, overflow at 0x0014..0x001A.
// - Timer 0 compare A, compare B, overflow at 0x001C/0x001E/0x0020.
// - Serial transfer complete vectors to 0x0022.
// - Serial receive, transmit empty, transmit done at 0x0024/0x0026/0x0028.
// - Converter, data memory, comparator, two-wire, store ready 0x002A..0x0032.
// - Vector select set adds boot section start to every vector offset.
// - Programmed boot-reset fuse starts execution at boot reset address.
// - Boot-reset fuse value 1 is unprogrammed, 0 is programmed.
// - Reset target and table base are chosen independently.
`ifndef RIVM_MAP_SVH
`define RIVM_MAP_SVH
`define RIVM_ADDR_W 14
`define RIVM_NUM_IRQ 25
`define RIVM_RESET_ADDR 14'h0000
`define RIVM_TABLE_BASE 14'h0002
`define RIVM_VEC_STEP 14'h0002
`define RIVM_FUSE_PROGRAMMED 1'b0
`define RIVM_BOOT_RESET_ADDR 14'h1c00
`define RIVM_NO_BOOT_BASE 14'h0000
// Edges after release before stage two holds the real fuse level
`define RIVM_SETTLE_CYCLES 2'h2
`define RIVM_OFS_EXT_REQ_0 14'h0002
`define RIVM_OFS_EXT_REQ_1 14'h0004
`define RIVM_OFS_PIN_CHG_0 14'h0006
`define RIVM_OFS_PIN_CHG_1 14'h0008
`define RIVM_OFS_PIN_CHG_2 14'h000a
`define RIVM_OFS_WDOG_TIMEOUT 14'h000c
`define RIVM_OFS_T2_CMP_A 14'h000e
`define RIVM_OFS_T2_CMP_B 14'h0010
`define RIVM_OFS_T2_OVF 14'h0012
`define RIVM_OFS_T1_CAPT 14'h0014
`define RIVM_OFS_T1_CMP_A 14'h0016
`define RIVM_OFS_T1_CMP_B 14'h0018
`define RIVM_OFS_T1_OVF 14'h001a
`define RIVM_OFS_T0_CMP_A 14'h001c
`define RIVM_OFS_T0_CMP_B 14'h001e
`define RIVM_OFS_T0_OVF 14'h0020
`define RIVM_OFS_SER_XFER_DONE 14'h0022
`define RIVM_OFS_RX_DONE 14'h0024
`define RIVM_OFS_TX_DATA_EMPTY 14'h0026
`define RIVM_OFS_TX_DONE 14'h0028
`define RIVM_OFS_CONV_DONE 14'h002a
`define RIVM_OFS_DATA_NVM_READY 14'h002c
`define RIVM_OFS_CMP_EVENT 14'h002e
`define RIVM_OFS_TWO_WIRE 14'h0030
`define RIVM_OFS_PROG_STORE_READY 14'h0032
`endif

// file: include/rivm_pkg.sv
// Types of the reset and vector map
package rivm_pkg;
    typedef logic [13:0] rivm_addr_t;
    typedef enum logic [1:0] {RIVM_IDLE, RIVM_RESET, RIVM_IRQ} rivm_kind_t;
endpackage

// file: sim/reset_interrupt_vector_map_test.sv
// Self-checking bench of the vector map
`timescale 1ns/1ps
`default_nettype none
`include "rivm_map.svh"
module reset_interrupt_vector_map_test;
    logic clk = 1'h0, nrst = 1'h0, fuse = 1'h0, sel = 1'h0, ack, v, r;
    logic [24:0] irq = 25'h0;
    logic [13:0] a;
    logic [4:0] x;
    int fails = 0, checks = 0;
    rivm_vector_map DUT (.I_MCLK(clk), .I_NRST(nrst), .I_ACK(ack), .I_IRQ(irq),
        .I_BOOT_RESET_FUSE(fuse), .I_VECTOR_TABLE_SELECT(sel), .O_IS_RESET(r),
        .O_VEC_VALID(v), .O_VEC_ADDR(a), .O_IRQ_IDX(x));
    rivm_core_model u_core (.i_clk(clk), .i_valid(v), .i_slow(sel), .o_ack(ack));
    initial forever #10 clk = ~clk;
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end
    task automatic vec(int k);
        logic [20:0] e;
        e = {2'h2, {14{sel}} & `RIVM_BOOT_RESET_ADDR, 5'(k)};
        e[18:5] = e[18:5] + 14'(2 * k + 2);
        if (k < 0) e = {2'h3, {14{!fuse}} & `RIVM_BOOT_RESET_ADDR, 5'h0};
        for (int i = 0; i < 40 && v !== 1'h1; i++) @(posedge clk) #1;
        checks++;
        if ({v, r, a, r ? 5'h0 : x} !== e) begin
            fails++;
            $display("[FAIL] vector expected %h seen %h", e, {v, r, a, x});
        end
        if (k >= 0) irq[k] = 1'h0;
        for (int i = 0; i < 40 && v === 1'h1; i++) @(posedge clk) #1;
    endtask
    task automatic t_map();
        for (int m = 0; m < 4; m++) begin
            nrst = 1'h0;
            {fuse, sel} = 2'(m);
            repeat (5) @(posedge clk) #1;
            nrst = 1'h1;
            vec(-1);
            for (int k = 0; k < 25; k++) begin
                irq[k] = 1'h1;
                vec(k);
            end
        end
        $display("t_map done");
    endtask
    task automatic t_prio();
        irq = 25'h1000011;
        vec(0);
        vec(4);
        vec(24);
        $display("t_prio done");
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        t_map();
        t_prio();
        give_verdict();
    end
endmodule
`default_nettype wire

// file: sim/rivm_core_model.sv
// Core model taking each vector after a delay
`timescale 1ns/1ps
`default_nettype none
module rivm_core_model (
    input wire logic i_clk,
    input wire logic i_valid,
    input wire logic i_slow,
    output logic o_ack = 1'h0
);
    int n = 0;
    // Delay of three (nine with i_slow) covers the request sync, so a cleared source is seen
    always @(posedge i_clk) begin
        n = (i_valid && !o_ack) ? n + 1 : 0;
        o_ack <= i_valid && n >= (i_slow ? 9 : 3);
    end
endmodule
`default_nettype wire

// file: sim/rivm_vector_map_assertions.sv
// Port assertions of the vector map
`timescale 1ns/1ps
`default_nettype none
`include "rivm_map.svh"
module rivm_chk (input wire logic I_MCLK, I_NRST, I_ACK, O_VEC_VALID,
    input wire logic I_BOOT_RESET_FUSE, I_VECTOR_TABLE_SELECT, O_IS_RESET,
    input wire logic [24:0] I_IRQ, input wire logic [13:0] O_VEC_ADDR,
    input wire logic [4:0] O_IRQ_IDX);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    wire [13:0] boot = {14{I_VECTOR_TABLE_SELECT}} & `RIVM_BOOT_RESET_ADDR;
    wire [13:0] rsta = {14{!I_BOOT_RESET_FUSE}} & `RIVM_BOOT_RESET_ADDR;
    wire irq = O_VEC_VALID && !O_IS_RESET;
    sequence s_rst; O_VEC_VALID && O_IS_RESET; endsequence
    AST_RST_TIME: assert property ($rose(I_NRST) |-> ##[1:12] s_rst)
        else $error("no reset vector");
    AST_RST_ADDR: assert property (s_rst |-> O_VEC_ADDR == rsta)
        else $error("bad reset address");
    AST_IRQ_ADDR: assert property (irq |-> O_VEC_ADDR ==
        boot + 14'h2 + {O_IRQ_IDX, 1'h0}) else $error("bad vector address");
    AST_IDX: assert property (irq |-> O_IRQ_IDX < 5'h19)
        else $error("bad index");
    AST_PRIO: assert property ($rose(O_VEC_VALID) && irq |->
        ($past(I_IRQ, 3) & ((25'h2 << O_IRQ_IDX) - 25'h1)) == 25'h1 << O_IRQ_IDX)
        else $error("not lowest request");
    AST_HOLD: assert property (O_VEC_VALID && !I_ACK |=>
        O_VEC_VALID && $stable({O_VEC_ADDR, O_IRQ_IDX})) else $error("not held");
    AST_DROP: assert property (O_VEC_VALID && I_ACK |=> !O_VEC_VALID)
        else $error("kept after ack");
    AST_GAP: assert property ($fell(O_VEC_VALID) |-> $past(I_ACK))
        else $error("vector dropped without ack");
endmodule
bind rivm_vector_map rivm_chk u_chk (.I_MCLK, .I_NRST, .I_ACK, .O_VEC_VALID,
    .I_BOOT_RESET_FUSE, .I_VECTOR_TABLE_SELECT, .O_IS_RESET, .I_IRQ,
    .O_VEC_ADDR, .O_IRQ_IDX);
`default_nettype wire
